/* File: src/fpc_pkg.sv */
// shared constants and types for the flash command controller
package fpc_pkg;
  // ****************************************
  // widths and timing
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 10;
  localparam int T_WE_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_GAP_NS = 30;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam logic [7:0] WE_CYC = 8'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RH_CYC = 8'((T_RH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SYNC_CYC = 8'h02;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam int CTRL_ACCEL_BIT = 8;
  localparam int CTRL_UNLOCK_BIT = 9;
  localparam int CTRL_FRST_BIT = 10;
  localparam int ST_BUSY = 0;
  localparam int ST_SUSP = 1;
  localparam int ST_TOG1 = 2;
  localparam int ST_TOG2 = 3;
  localparam int ST_TMO = 4;
  localparam int ST_ABORT = 5;
  localparam int ST_POLL_OK = 6;
  localparam int ST_ACCEL = 7;
  localparam int ST_FRST = 8;
  // ****************************************
  // flash data bus status bits and commands
  // ****************************************
  localparam int POLL_BIT = 7;
  localparam int TOG1_BIT = 6;
  localparam int TMO_BIT = 5;
  localparam int TOG2_BIT = 2;
  localparam int ABORT_BIT = 1;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_UNLK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SSR_ENTER = 8'h88;
  localparam logic [7:0] CMD_SSR_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_SSR_EXIT2 = 8'h00;
  localparam logic [23:0] UNLK_ADDR1 = 24'h00_0555;
  localparam logic [23:0] UNLK_ADDR2 = 24'h00_02AA;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_WRITE = 3'b001,
    OP_READ = 3'b010,
    OP_SUSPEND = 3'b011,
    OP_RESUME = 3'b100,
    OP_ABORT_RST = 3'b101,
    OP_SSR_READ = 3'b110,
    OP_POLL = 3'b111
  } fpc_op_e;
endpackage

/* File: src/fpc_cyc_if.sv */
// request and answer of one flash bus cycle
`timescale 1ns/1ns
interface fpc_cyc_if;
  logic req;
  logic wr;
  logic [fpc_pkg::ADDR_W-1:0] addr;
  logic [fpc_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [fpc_pkg::DATA_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* File: src/fpc_cycle.sv */
// one asynchronous flash write or read cycle on the pins
`timescale 1ns/1ns
module fpc_cycle (
  input wire logic core_clk,
  input wire logic rst,
  fpc_cyc_if.eng cyc,
  output logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [fpc_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_i
);
  import fpc_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_STRB = 2'b01,
    C_HOLD = 2'b10,
    C_DONE = 2'b11
  } fpc_ph_e;

  typedef struct packed {
    fpc_ph_e ph;
    logic [7:0] cnt;
    logic wr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [DATA_W-1:0] dq_o;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } fpc_cyc_s;

  fpc_cyc_s s_reg;
  fpc_cyc_s s_next;

  // ****************************************
  // cycle sequencing
  // ****************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = flash_dq_i;
    s_next.sync2 = s_reg.sync1;
    s_next.done = 1'b0;
    unique case (s_reg.ph)
      C_IDLE:
        if (cyc.req)
        begin
          s_next.ph = C_STRB;
          s_next.wr = cyc.wr;
          s_next.addr = cyc.addr;
          s_next.dq_o = cyc.wdata;
          s_next.ce_n = 1'b0;
          s_next.we_n = !cyc.wr;
          s_next.oe_n = cyc.wr;
          s_next.dq_oe = cyc.wr;
          // reads wait out the synchroniser as well as access time
          s_next.cnt = cyc.wr ? WE_CYC : 8'(ACC_CYC + SYNC_CYC);
        end
      C_STRB:
        if (s_reg.cnt > 8'h01)
          s_next.cnt = s_reg.cnt - 8'h01;
        else
        begin
          s_next.ph = C_HOLD;
          s_next.cnt = GAP_CYC;
          // strobes rise together so every status read is a separate cycle
          s_next.ce_n = 1'b1;
          s_next.we_n = 1'b1;
          s_next.oe_n = 1'b1;
          if (!s_reg.wr)
            s_next.rdata = s_reg.sync2;
        end
      C_HOLD:
        if (s_reg.cnt > 8'h01)
          s_next.cnt = s_reg.cnt - 8'h01;
        else
        begin
          // data kept on through the gap: latched at the rising strobe
          s_next.dq_oe = 1'b0;
          s_next.ph = C_DONE;
          s_next.done = 1'b1;
        end
      C_DONE:
        s_next.ph = C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.ce_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign cyc.done = s_reg.done;
  assign cyc.rdata = s_reg.rdata;
  assign flash_addr = s_reg.addr;
  assign flash_ce_n = s_reg.ce_n;
  assign flash_we_n = s_reg.we_n;
  assign flash_oe_n = s_reg.oe_n;
  assign flash_dq_o = s_reg.dq_o;
  assign flash_dq_oe = s_reg.dq_oe;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_NO_CONTENTION: assert property (!(!flash_oe_n && flash_dq_oe))
    else $error("read strobe while driving data");
  AST_STROBE_GAP: assert property ($rose(flash_oe_n) |-> flash_ce_n [*3])
    else $error("chip enable not high between reads");
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n [*4])
    else $error("write strobe too short");
endmodule

/* File: src/fpc_top.sv */
// host controller: bus registers, command sequences and status polling
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
module fpc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [fpc_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_i,
  output logic flash_reset_n,
  output logic accel_hv_en
);
  import fpc_pkg::*;

  localparam logic [1:0] A_USER = 2'b00;
  localparam logic [1:0] A_555 = 2'b01;
  localparam logic [1:0] A_2AA = 2'b10;

  typedef struct packed {
    logic last;
    logic wr;
    logic [1:0] asel;
    logic user_d;
    logic [7:0] d;
  } fpc_step_s;

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic wpend;
    logic [7:0] waddr;
    fpc_op_e op;
    logic busy;
    logic [2:0] idx;
    logic req;
    logic c_wr;
    logic [ADDR_W-1:0] c_addr;
    logic [DATA_W-1:0] c_wdata;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] first_r;
    logic suspended;
    logic unlocked;
    logic accel_req;
    logic accel_hv;
    logic frst_n;
    logic [7:0] rcnt;
    logic st_tog1;
    logic st_tog2;
    logic st_tmo;
    logic st_abort;
    logic st_poll_ok;
  } fpc_top_s;

  fpc_top_s s_reg;
  fpc_top_s s_next;
  fpc_cyc_if cyc ();

  // ****************************************
  // command sequences, one step per bus cycle
  // ****************************************
  function automatic fpc_step_s fpc_step(input fpc_op_e op, input logic [2:0] idx);
    fpc_step_s t;
    t = '{last: 1'b1, wr: 1'b1, asel: A_USER, user_d: 1'b0, d: 8'h00};
    unique case (op)
      OP_NONE: ;
      OP_WRITE: t.user_d = 1'b1;
      OP_READ: t.wr = 1'b0;
      OP_SUSPEND: t.d = CMD_SUSPEND;
      OP_RESUME: t.d = CMD_RESUME;
      OP_POLL:
      begin
        // two separate reads of the same word expose toggling
        t.wr = 1'b0;
        t.last = (idx == 3'h1);
      end
      OP_ABORT_RST, OP_SSR_READ:
      begin
        t.last = (op == OP_ABORT_RST) ? (idx == 3'h2) : (idx == 3'h7);
        unique case (idx[1:0])
          2'b00:
          begin
            t.asel = A_555;
            t.d = CMD_UNLK1;
          end
          2'b01:
          begin
            t.asel = A_2AA;
            t.d = CMD_UNLK2;
          end
          2'b10:
          begin
            t.asel = A_555;
            if (op == OP_ABORT_RST)
              t.d = CMD_RESET;
            else
              t.d = idx[2] ? CMD_SSR_EXIT1 : CMD_SSR_ENTER;
          end
          2'b11:
          begin
            // read inside the secured area, then the final exit write
            t.wr = idx[2];
            t.d = CMD_SSR_EXIT2;
          end
        endcase
      end
    endcase
    return t;
  endfunction

  fpc_step_s step;
  logic [31:0] rd;

  // ****************************************
  // register read view
  // ****************************************
  always_comb
  begin
    rd = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_CTRL:
      begin
        rd[CTRL_ACCEL_BIT] = s_reg.accel_req;
        rd[CTRL_UNLOCK_BIT] = s_reg.unlocked;
        rd[2:0] = s_reg.op;
      end
      OFS_ADDR: rd[ADDR_W-1:0] = s_reg.addr_r;
      OFS_WDATA: rd[DATA_W-1:0] = s_reg.wdata_r;
      OFS_STATUS:
      begin
        rd[ST_BUSY] = s_reg.busy;
        rd[ST_SUSP] = s_reg.suspended;
        rd[ST_TOG1] = s_reg.st_tog1;
        rd[ST_TOG2] = s_reg.st_tog2;
        rd[ST_TMO] = s_reg.st_tmo;
        rd[ST_ABORT] = s_reg.st_abort;
        rd[ST_POLL_OK] = s_reg.st_poll_ok;
        rd[ST_ACCEL] = s_reg.accel_hv;
        rd[ST_FRST] = !s_reg.frst_n;
      end
      OFS_RDATA: rd[DATA_W-1:0] = s_reg.rdata_r;
      default: rd = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // bus slave, sequencer and status capture
  // ****************************************
  always_comb
  begin
    step = fpc_step(s_reg.op, s_reg.idx);
    s_next = s_reg;
    if (hsel && htrans[1] && hready)
    begin
      if (hwrite && hsize == 3'b010)
      begin
        s_next.wpend = 1'b1;
        s_next.waddr = haddr[7:0];
      end
      else if (!hwrite)
        s_next.hrdata = rd;
    end
    if (s_reg.wpend)
    begin
      s_next.wpend = 1'b0;
      unique case (s_reg.waddr)
        OFS_CTRL:
        begin
          s_next.accel_req = hwdata[CTRL_ACCEL_BIT];
          s_next.unlocked = hwdata[CTRL_UNLOCK_BIT];
          if (!s_reg.busy && s_reg.rcnt == 8'h00)
          begin
            if (hwdata[CTRL_FRST_BIT])
            begin
              // a hardware reset forgets any suspended program
              s_next.frst_n = 1'b0;
              s_next.rcnt = 8'(RP_CYC + RH_CYC);
              s_next.suspended = 1'b0;
              s_next.st_abort = 1'b0;
              s_next.st_tmo = 1'b0;
            end
            else if (fpc_op_e'(hwdata[2:0]) != OP_NONE
                     && !(fpc_op_e'(hwdata[2:0]) == OP_SUSPEND && s_reg.suspended)
                     && !(fpc_op_e'(hwdata[2:0]) == OP_RESUME && !s_reg.suspended))
            begin
              s_next.op = fpc_op_e'(hwdata[2:0]);
              s_next.busy = 1'b1;
              s_next.idx = 3'h0;
            end
          end
        end
        OFS_ADDR: s_next.addr_r = hwdata[ADDR_W-1:0];
        OFS_WDATA: s_next.wdata_r = hwdata[DATA_W-1:0];
        default: ;
      endcase
    end
    if (s_reg.rcnt != 8'h00)
    begin
      s_next.rcnt = s_reg.rcnt - 8'h01;
      if (s_reg.rcnt == RH_CYC)
        s_next.frst_n = 1'b1;
    end
    // high voltage only with software vouching the sectors are unlocked
    s_next.accel_hv = s_reg.accel_req && s_reg.unlocked && s_reg.frst_n;
    if (s_reg.busy && !s_reg.req && !cyc.done)
    begin
      s_next.req = 1'b1;
      s_next.c_wr = step.wr;
      s_next.c_wdata = step.user_d ? s_reg.wdata_r : {8'h00, step.d};
      unique case (step.asel)
        A_555: s_next.c_addr = UNLK_ADDR1;
        A_2AA: s_next.c_addr = UNLK_ADDR2;
        default: s_next.c_addr = s_reg.addr_r;
      endcase
    end
    if (s_reg.busy && cyc.done)
    begin
      s_next.req = 1'b0;
      if (!s_reg.c_wr)
      begin
        s_next.rdata_r = cyc.rdata;
        if (s_reg.idx == 3'h0)
          s_next.first_r = cyc.rdata;
      end
      if (step.last)
      begin
        s_next.busy = 1'b0;
        s_next.op = OP_NONE;
        unique case (s_reg.op)
          OP_SUSPEND: s_next.suspended = 1'b1;
          OP_RESUME: s_next.suspended = 1'b0;
          OP_ABORT_RST: s_next.st_abort = 1'b0;
          OP_POLL:
          begin
            s_next.st_tog1 = s_reg.first_r[TOG1_BIT] ^ cyc.rdata[TOG1_BIT];
            s_next.st_tog2 = s_reg.first_r[TOG2_BIT] ^ cyc.rdata[TOG2_BIT];
            // flag bits are array data once toggling stops, so only trust them while it runs
            s_next.st_tmo = s_next.st_tog1 && cyc.rdata[TMO_BIT];
            s_next.st_abort = s_next.st_tog1 && cyc.rdata[ABORT_BIT];
            // second read decides: bit seven alone may settle early
            s_next.st_poll_ok =
              cyc.rdata[POLL_BIT] == s_reg.wdata_r[POLL_BIT];
          end
          default: ;
        endcase
      end
      else
        s_next.idx = s_reg.idx + 3'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.hreadyout <= 1'b1;
      s_reg.frst_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign cyc.req = s_reg.req;
  assign cyc.wr = s_reg.c_wr;
  assign cyc.addr = s_reg.c_addr;
  assign cyc.wdata = s_reg.c_wdata;
  assign hreadyout = s_reg.hreadyout;
  assign hrdata = s_reg.hrdata;
  assign hresp = s_reg.hresp;
  assign flash_reset_n = s_reg.frst_n;
  assign accel_hv_en = s_reg.accel_hv;

  fpc_cycle i_fpc_cycle (
    .core_clk(core_clk),
    .rst(rst),
    .cyc(cyc),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_SUSPEND_SETS: assert property (
    (s_reg.busy && s_reg.op == OP_SUSPEND && cyc.done) |=> s_reg.suspended && !s_reg.busy)
    else $error("suspend did not mark suspended");
  AST_SUSPEND_DATA: assert property (
    (s_reg.req && s_reg.op == OP_SUSPEND) |-> s_reg.c_wr && s_reg.c_wdata[7:0] == CMD_SUSPEND)
    else $error("suspend cycle carries wrong data");
  AST_RESUME_ONCE: assert property ((s_reg.busy && s_reg.op == OP_RESUME) |-> s_reg.suspended)
    else $error("resume issued while not suspended");
  AST_RESUME_CLEARS: assert property (
    (s_reg.busy && s_reg.op == OP_RESUME && cyc.done) |=> !s_reg.suspended)
    else $error("resume left suspended set");
  AST_ACCEL_UNLOCKED: assert property (accel_hv_en |-> $past(s_reg.unlocked))
    else $error("high voltage without unlock");
  AST_RESET_DROPS_SUSPEND: assert property (!flash_reset_n |-> !s_reg.suspended)
    else $error("suspend survived flash reset");
  AST_ABORT_RST_LEN: assert property (
    (s_reg.busy && s_reg.op == OP_ABORT_RST && cyc.done && s_reg.idx == 3'h2) |=> !s_reg.busy)
    else $error("abort reset not three cycles");
  AST_POLL_READS: assert property ((s_reg.req && s_reg.op == OP_POLL) |-> !s_reg.c_wr)
    else $error("poll issued a write");
endmodule

/* File: tb/fpc_flash_model.sv */
// behavioural flash device that answers the controller's strobes
`timescale 1ns/1ns
module fpc_flash_model #(
  parameter int PROG_NS = 8000
) (
  input wire logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe,
  output logic [fpc_pkg::DATA_W-1:0] flash_dq_i,
  input wire logic flash_reset_n,
  input wire logic accel_hv_en
);
  import fpc_pkg::*;
  localparam logic [15:0] SSR_WORD = 16'h5A3C;
  logic [15:0] pdata = 16'hFFFF;
  logic [15:0] dq_q = 16'h0000;
  logic [ADDR_W-1:0] paddr = 24'h00_0000;
  logic [7:0] c0 = 8'h00, c1 = 8'h00, d;
  logic busy = 1'b0, susp = 1'b0, tog = 1'b0, ssr = 1'b0;
  logic abort_flag = 1'b0, tmo_flag = 1'b0;
  int left = 0, resume_cnt = 0;
  assign flash_dq_i = dq_q;
  // strobes move together, so act on their combination rather than race them
  wire logic wstrobe_n;
  wire logic rstrobe_n;
  assign wstrobe_n = flash_we_n | flash_ce_n;
  assign rstrobe_n = flash_oe_n | flash_ce_n;
  // ****************************************
  // embedded program timer and commands
  // ****************************************
  // coarse 100 ns steps; a fault freezes it until the abort-reset
  always
  begin
    #100;
    if (busy && !susp && !abort_flag && !tmo_flag)
      if (left > 0)
        left--;
      else
        busy = 1'b0;
  end
  always @(posedge wstrobe_n)
  begin
    d = flash_dq_o[7:0];
    if (flash_dq_oe && flash_reset_n)
    begin
      if (ssr && c0 == CMD_SSR_EXIT1 && d == CMD_SSR_EXIT2)
        ssr = 1'b0;
      else if (d == CMD_SUSPEND)
        susp = busy;
      else if (d == CMD_RESUME && susp)
      begin
        susp = 1'b0;
        resume_cnt++;
      end
      else if (d == CMD_RESET && c0 == CMD_UNLK2 && c1 == CMD_UNLK1)
      begin
        abort_flag = 1'b0;
        tmo_flag = 1'b0;
        busy = 1'b0;
      end
      else if (d == CMD_SSR_ENTER && c0 == CMD_UNLK2)
        ssr = 1'b1;
      else if (!busy && !(d inside {CMD_UNLK1, CMD_UNLK2, CMD_RESET, CMD_SSR_EXIT1, 8'h00}))
      begin
        paddr = flash_addr;
        pdata = flash_dq_o;
        busy = 1'b1;
        left = accel_hv_en ? PROG_NS / 400 : PROG_NS / 100;
      end
      c1 = c0;
      c0 = d;
    end
  end
  // ****************************************
  // read answers
  // ****************************************
  always @(negedge rstrobe_n)
  begin
    // let the address launched with the strobe settle first
    #1;
    if (!flash_ce_n && ssr)
      dq_q = SSR_WORD;
    else if (!flash_ce_n && busy && !susp && flash_addr == paddr)
    begin
      dq_q = {8'h00, ~pdata[7], tog, tmo_flag, 3'b000, abort_flag, 1'b0};
      tog = ~tog;
    end
    else if (!flash_ce_n)
      dq_q = (flash_addr == paddr) ? pdata : 16'hFFFF;
  end
  // released bus shows the inverse, so a late sample cannot pass
  always @(posedge rstrobe_n)
    dq_q = ~dq_q;
  always @(negedge flash_reset_n)
  begin
    busy = 1'b0;
    susp = 1'b0;
    ssr = 1'b0;
    abort_flag = 1'b0;
    tmo_flag = 1'b0;
  end
endmodule

/* File: tb/tb_fpc_top.sv */
// self-checking bench for the flash command controller
`timescale 1ns/1ns
module tb_fpc_top;
  import fpc_pkg::*;
  localparam logic [31:0] M_SUSP = 32'h0000_0002, M_TOG = 32'h0000_0004;
  localparam logic [31:0] M_TMO = 32'h0000_0010, M_ABT = 32'h0000_0020;
  localparam logic [31:0] M_POLL = 32'h0000_0040, M_ACC = 32'h0000_0080;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
  logic flash_reset_n, accel_hv_en, rd_dphase = 1'b0;
  logic [31:0] hrdata, q, d, ctrl_hi = 32'h0000_0000;
  logic [31:0] exp_q[$], msk_q[$];
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_dq_o, flash_dq_i;
  int seed = 2009, error_cnt = 0, total_checks = 0, i, n;
  fpc_top i_fpc_top (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i),
    .flash_reset_n(flash_reset_n), .accel_hv_en(accel_hv_en));
  fpc_flash_model i_fpc_flash_model (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_reset_n(flash_reset_n),
    .accel_hv_en(accel_hv_en));
  initial
    forever #5 core_clk = ~core_clk;
  // ****************************************
  // bus tasks and result checking
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    total_checks++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  // one single transfer; read expectations are queued for the monitor
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
    input logic ce, input logic [31:0] ex, input logic [31:0] mk);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'($random(seed)), ofs};
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++k < 100);
    if (k >= 100)
      error_cnt++;
    htrans <= 2'b00;
    hwdata <= wd;
    rd_dphase <= !wr && ce;
    if (!wr && ce)
    begin
      exp_q.push_back(ex & mk);
      msk_q.push_back(mk);
    end
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++k < 200);
    if (k >= 200)
      error_cnt++;
    q = hrdata;
    rd_dphase <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] o, input logic [31:0] v);
    bus(1'b1, o, v, 1'b0, 32'h0000_0000, 32'h0000_0000);
  endtask
  task automatic rd_chk(input logic [7:0] o, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, o, 32'h0000_0000, 1'b1, e, m);
  endtask
  // busy and flash-reset both hold off the next order
  task automatic idle_wait();
    @(posedge core_clk);
    n = 0;
    do bus(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, 32'h0000_0000, 32'h0000_0000);
    while ((q[8:0] & 9'h101) !== 9'h000 && ++n < 500);
    if (n >= 500)
      error_cnt++;
  endtask
  task automatic op(input logic [2:0] c);
    wr(OFS_CTRL, ctrl_hi | 32'(c));
    idle_wait();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk)
    if (rd_dphase)
      chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
  initial
  begin
    #900_000;
    error_cnt++;
    tally_and_finish();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd_chk(OFS_STATUS, 32'h0000_0000, 32'h0000_01FF);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
    for (i = 0; i < 3; i++)
    begin
      d = ($random(seed) & 32'h0000_FFF0) | 32'h0000_0007;
      wr(OFS_ADDR, $random(seed) & 32'h00FF_FFFF);
      wr(OFS_WDATA, d);
      op(3'd1);
      op(3'd7);
      rd_chk(OFS_STATUS, M_TOG, M_TOG | M_POLL);
      op(3'd3);
      rd_chk(OFS_STATUS, M_SUSP, M_SUSP);
      op(3'd7);
      rd_chk(OFS_STATUS, 32'h0000_0000, M_TOG);
      if (i == 0)
      begin
        op(3'd6);
        rd_chk(OFS_RDATA, 32'h0000_5A3C, 32'h0000_FFFF);
        chk(32'(i_fpc_flash_model.ssr), 32'h0000_0000);
      end
      op(3'd3);
      op(3'd4);
      rd_chk(OFS_STATUS, 32'h0000_0000, M_SUSP);
      op(3'd4);
      chk(32'(i_fpc_flash_model.resume_cnt), 32'(i + 1));
      n = 0;
      do op(3'd7); while (q[ST_TOG1] !== 1'b0 && ++n < 100);
      if (n >= 100)
        error_cnt++;
      rd_chk(OFS_STATUS, M_POLL, M_TOG | M_POLL);
      op(3'd2);
      rd_chk(OFS_RDATA, d, 32'h0000_FFFF);
    end
    // high voltage only once sectors are marked unlocked
    ctrl_hi = 32'h0000_0100;
    wr(OFS_CTRL, ctrl_hi);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(accel_hv_en), 32'h0000_0000);
    @(posedge core_clk);
    ctrl_hi = 32'h0000_0300;
    wr(OFS_CTRL, ctrl_hi);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(accel_hv_en), 32'h0000_0001);
    @(posedge core_clk);
    rd_chk(OFS_STATUS, M_ACC, M_ACC);
    op(3'd1);
    i_fpc_flash_model.abort_flag = 1'b1;
    op(3'd7);
    rd_chk(OFS_STATUS, M_ABT | M_TOG, M_ABT | M_TOG);
    op(3'd5);
    op(3'd7);
    rd_chk(OFS_STATUS, M_POLL, M_ABT | M_TOG | M_POLL);
    ctrl_hi = 32'h0000_0000;
    op(3'd1);
    i_fpc_flash_model.tmo_flag = 1'b1;
    op(3'd7);
    rd_chk(OFS_STATUS, M_TMO, M_TMO);
    op(3'd5);
    op(3'd1);
    op(3'd3);
    wr(OFS_CTRL, 32'h0000_0400);
    idle_wait();
    rd_chk(OFS_STATUS, 32'h0000_0000, 32'h0000_0103 | M_TMO | M_ABT);
    chk(32'(i_fpc_flash_model.busy), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
